// ===== src/rxpsc_pkg.sv
// rxpsc_pkg: constants for the receiver start-up and squelch controller
// assumes a 100 MHz system clock; nothing outside relies upon its order
package rxpsc_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int CHANNEL_CHANGE_TIME_US = 1500;
	localparam int WAKE_FROM_POWERDOWN_TIME_US = 3000;
	localparam int WAKE_FROM_SUPPLY_TIME_US = 7000;
	localparam int MAX_TRANSITION_GAP_US = 20000;
	// each time converts exactly to whole cycles at CLK_MHZ
	localparam int CHANNEL_CHANGE_CYC = CHANNEL_CHANGE_TIME_US * CLK_MHZ;
	localparam int WAKE_PD_CYC = WAKE_FROM_POWERDOWN_TIME_US * CLK_MHZ;
	localparam int WAKE_SUPPLY_CYC = WAKE_FROM_SUPPLY_TIME_US * CLK_MHZ;
	localparam int GAP_CYC = MAX_TRANSITION_GAP_US * CLK_MHZ;
	localparam int CNT_W = 24;
	// cycles kept back from each settle for the buffer and output stage
	localparam int BUF_LAT = 4;
	// ----------------------------------------------------------------
	// levels and sizes
	// ----------------------------------------------------------------
	localparam int CHAN_W = 3;
	localparam int FIFO_DEPTH = 8;
	localparam logic IDLE_LEVEL = 1'b1;
	localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
	// ----------------------------------------------------------------
	// sequencer states, gray along off -> program -> settle -> run
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RXPSC_OFF = 2'h0,
		RXPSC_PROG = 2'h1,
		RXPSC_SETTLE = 2'h3,
		RXPSC_RUN = 2'h2
	} rxpsc_state_t;
endpackage

// ===== src/rxpsc_fifo.sv
// rxpsc_fifo: the sample fifo module sits beside rxpsc_top in its file
// assumes rxpsc_top.sv is read as well; this file holds no logic

// ===== src/rxpsc_top.sv
// rxpsc_top: power-down, start-up sequencing and data squelch of a receiver
// assumes all pins are synchronous to clk; the demodulator lives outside
`timescale 1ns/1ps
module rxpsc_top #(
	parameter int WAKE_SUPPLY_CYC = rxpsc_pkg::WAKE_SUPPLY_CYC,
	parameter int WAKE_PD_CYC = rxpsc_pkg::WAKE_PD_CYC,
	parameter int CHANGE_CYC = rxpsc_pkg::CHANNEL_CHANGE_CYC,
	parameter int GAP_CYC = rxpsc_pkg::GAP_CYC,
	parameter int DEPTH = rxpsc_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic power_down_n,
	input wire logic chan_sel_bit0,
	input wire logic chan_sel_bit1,
	input wire logic chan_sel_bit2,
	input wire logic sel_mode,
	input wire logic demod_valid,
	input wire logic demod_bit,
	input wire logic signal_ok,
	output logic demod_ready,
	output logic data_out,
	output logic synth_load,
	output logic [rxpsc_pkg::CHAN_W-1:0] synth_chan,
	output logic serial_mode,
	output logic rx_enable,
	output logic gap_fault
);
	localparam int CW = rxpsc_pkg::CNT_W;
	rxpsc_pkg::rxpsc_state_t st_r, st_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [rxpsc_pkg::CHAN_W-1:0] chan_r, chan_nxt, pins;
	logic cold_r, cold_nxt;
	logic load_r, load_nxt, mode_r, mode_nxt, en_r, en_nxt;
	logic dout_r, dout_nxt;
	logic [CW-1:0] gap_r, gap_nxt;
	logic last_r, last_nxt, gfault_r, gfault_nxt;
	logic f_valid, f_data, f_pop, run, live;

	// ----------------------------------------------------------------
	// data buffer
	// ----------------------------------------------------------------
	// samples only enter while running; flushing at exit drops stale bits
	rxpsc_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.flush(!run),
		.in_valid(demod_valid && run),
		.in_ready(demod_ready),
		.in_data(demod_bit),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	// ----------------------------------------------------------------
	// start-up sequencer
	// ----------------------------------------------------------------
	always_comb begin
		pins = {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};
		run = st_r == rxpsc_pkg::RXPSC_RUN;
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		chan_nxt = chan_r;
		cold_nxt = cold_r;
		mode_nxt = mode_r;
		load_nxt = 1'b0;
		en_nxt = 1'b1;
		case (st_r)
			rxpsc_pkg::RXPSC_OFF: begin
				en_nxt = 1'b0;
				// an undriven pin reads high through the pull-up, so wakes
				if (power_down_n) begin
					st_nxt = rxpsc_pkg::RXPSC_PROG;
				end
			end
			rxpsc_pkg::RXPSC_PROG: begin
				chan_nxt = pins;
				mode_nxt = sel_mode;
				load_nxt = 1'b1;
				// settle budget leaves a few cycles for buffer latency
				cnt_nxt = CW'(cold_r ? WAKE_SUPPLY_CYC : WAKE_PD_CYC)
					- CW'(DEPTH + rxpsc_pkg::BUF_LAT);
				st_nxt = rxpsc_pkg::RXPSC_SETTLE;
			end
			rxpsc_pkg::RXPSC_SETTLE: begin
				if (cnt_r == '0) begin
					st_nxt = rxpsc_pkg::RXPSC_RUN;
					cold_nxt = 1'b0;
				end else begin
					cnt_nxt = CW'(cnt_r - 1'b1);
				end
			end
			rxpsc_pkg::RXPSC_RUN: begin
				if (pins != chan_r) begin
					chan_nxt = pins;
					load_nxt = 1'b1;
					cnt_nxt = CW'(CHANGE_CYC)
						- CW'(DEPTH + rxpsc_pkg::BUF_LAT);
					st_nxt = rxpsc_pkg::RXPSC_SETTLE;
				end
			end
			default: st_nxt = rxpsc_pkg::RXPSC_OFF;
		endcase
		if (!power_down_n) begin
			st_nxt = rxpsc_pkg::RXPSC_OFF;
			en_nxt = 1'b0;
			load_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= rxpsc_pkg::RXPSC_OFF;
			cnt_r <= '0;
			chan_r <= rxpsc_pkg::CHAN_RST;
			cold_r <= 1'b1;
			mode_r <= 1'b0;
			load_r <= 1'b0;
			en_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			chan_r <= chan_nxt;
			cold_r <= cold_nxt;
			mode_r <= mode_nxt;
			load_r <= load_nxt;
			en_r <= en_nxt;
		end
	end

	// ----------------------------------------------------------------
	// squelch and output stage
	// ----------------------------------------------------------------
	// fifo always drains one bit a cycle: it never holds more than one bit, never stalls
	always_comb begin
		f_pop = 1'b1;
		// power-down squelches at the very edge it is seen, not one later
		live = run && signal_ok && power_down_n;
		dout_nxt = rxpsc_pkg::IDLE_LEVEL;
		if (live && f_valid) begin
			dout_nxt = f_data;
		end else if (live) begin
			dout_nxt = dout_r;
		end
		// long-run watch: the fault flag is a hint, it changes nothing
		last_nxt = dout_r;
		gap_nxt = (dout_r != last_r || !run || !signal_ok) ? '0 :
			(gap_r == CW'(GAP_CYC) ? gap_r : CW'(gap_r + 1'b1));
		gfault_nxt = run && signal_ok && (gap_r == CW'(GAP_CYC));
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dout_r <= rxpsc_pkg::IDLE_LEVEL;
			last_r <= rxpsc_pkg::IDLE_LEVEL;
			gap_r <= '0;
			gfault_r <= 1'b0;
		end else begin
			dout_r <= dout_nxt;
			last_r <= last_nxt;
			gap_r <= gap_nxt;
			gfault_r <= gfault_nxt;
		end
	end

	always_comb begin
		data_out = dout_r;
		synth_load = load_r;
		synth_chan = chan_r;
		serial_mode = mode_r;
		rx_enable = en_r;
		gap_fault = gfault_r;
	end
endmodule

// ----------------------------------------------------------------
// rxpsc_fifo: small synchronous fifo for the sliced data samples
// ----------------------------------------------------------------
// one clock; flush empties it in one cycle
module rxpsc_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic push, pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		in_ready = (cnt_r != (AW+1)'(DEPTH)) || pop;
		out_valid = cnt_r != '0;
		out_data = mem[rp_r];
		wp_nxt = push ? AW'(wp_r + 1'b1) : wp_r;
		rp_nxt = pop ? AW'(rp_r + 1'b1) : rp_r;
		cnt_nxt = (AW+1)'(cnt_r + push - pop);
		if (flush) begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_r] <= in_data;
		end
	end
endmodule

// ===== tb/rxpsc_sva.sv
// rxpsc_sva: pin assertions for the receiver controller
// assumes a bind onto rxpsc_top
`timescale 1ns/1ps
module rxpsc_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic power_down_n,
	input wire logic chan_sel_bit0,
	input wire logic chan_sel_bit1,
	input wire logic chan_sel_bit2,
	input wire logic signal_ok,
	input wire logic data_out,
	input wire logic synth_load,
	input wire logic [rxpsc_pkg::CHAN_W-1:0] synth_chan,
	input wire logic rx_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_load; synth_load; endsequence
	// settle is longer than eight cycles in every build
	sequence s_quiet; data_out [*8]; endsequence
	property p_off; !power_down_n |=> !rx_enable; endproperty
	a_off: assert property (p_off) else $error("rx enabled");
	property p_pdq; !power_down_n |=> data_out; endproperty
	a_pdq: assert property (p_pdq) else $error("pd data");
	property p_weak; !signal_ok |=> data_out; endproperty
	a_weak: assert property (p_weak) else $error("weak data");
	property p_wake; $rose(power_down_n) |-> ##[1:2] s_load; endproperty
	a_wake: assert property (p_wake) else $error("no start");
	property p_chan; s_load |-> synth_chan ==
		$past({chan_sel_bit2, chan_sel_bit1, chan_sel_bit0}); endproperty
	a_chan: assert property (p_chan) else $error("bad chan");
	property p_oneshot; s_load |=> !synth_load; endproperty
	a_oneshot: assert property (p_oneshot) else $error("long load");
	property p_settle; s_load |=> s_quiet; endproperty
	a_settle: assert property (p_settle) else $error("early data");
	property p_fall; $fell(data_out) |-> $past(signal_ok) && rx_enable;
	endproperty
	a_fall: assert property (p_fall) else $error("bad fall");
endmodule

// ===== tb/rxpsc_src.sv
// rxpsc_src: stand-in demodulator, alternating bits
// assumes the bench clock; drives at the falling edge; hold stops samples
`timescale 1ns/1ps
module rxpsc_src (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ready,
	input wire logic hold,
	output logic valid,
	output logic bit_o
);
	always @(negedge clk or negedge rst_b) begin
		if (!rst_b) begin
			valid <= 1'b0;
			bit_o <= 1'b1;
		end else begin
			valid <= ~valid & ready & ~hold;
			bit_o <= valid ? ~bit_o : bit_o;
		end
	end
endmodule

// ===== tb/rxpsc_top_tb.sv
// rxpsc_top_tb: directed tests of start-up, power-down and squelch
// assumes shortened wake counts set below
`timescale 1ns/1ps
module rxpsc_top_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic power_down_n = 1'b1;
	logic [2:0] cs = 3'h0;
	logic signal_ok = 1'b1;
	logic sel_mode = 1'b0;
	logic hold = 1'b0;
	logic dv, db, demod_ready, data_out, synth_load, rx_enable;
	logic serial_mode, gap_fault;
	logic [rxpsc_pkg::CHAN_W-1:0] synth_chan;
	int n_errors = 0;
	int n_checks = 0;
	int n;
	int m;
	always #5 clk = ~clk;
	rxpsc_top #(.WAKE_SUPPLY_CYC(100), .WAKE_PD_CYC(60), .CHANGE_CYC(40),
		.GAP_CYC(200), .DEPTH(8)) rxpsc_top_inst (.clk(clk), .rst_b(rst_b),
		.power_down_n(power_down_n), .chan_sel_bit0(cs[0]),
		.chan_sel_bit1(cs[1]), .chan_sel_bit2(cs[2]), .sel_mode(sel_mode),
		.demod_valid(dv), .demod_bit(db), .signal_ok(signal_ok),
		.demod_ready(demod_ready), .data_out(data_out),
		.synth_load(synth_load), .synth_chan(synth_chan),
		.serial_mode(serial_mode), .rx_enable(rx_enable),
		.gap_fault(gap_fault));
	rxpsc_src rxpsc_src_inst (.clk(clk), .rst_b(rst_b),
		.ready(demod_ready), .hold(hold), .valid(dv), .bit_o(db));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
		n_checks++;
		if (e !== g) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_fall(int lim, output int c);
		c = 0;
		while (data_out !== 1'b0 && c < lim + 20) begin
			@(negedge clk);
			c++;
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_pd;
		power_down_n = 1'b0;
		sel_mode = 1'b1;
		repeat (3) @(negedge clk);
		chk("rx_enable", 3'h0, {2'h0, rx_enable});
		chk("pd data", 3'h1, {2'h0, data_out});
		power_down_n = 1'b1;
		wait_fall(60, n);
		chk("pd wake", 3'h1, {2'h0, n <= 60});
		chk("serial_mode", 3'h1, {2'h0, serial_mode});
		chk("rx_enable up", 3'h1, {2'h0, rx_enable});
		$display("test pd done");
	endtask
	task automatic t_chan;
		n = 0;
		cs = 3'h5;
		while (synth_load !== 1'b1 && n < 5) begin
			@(negedge clk);
			n++;
		end
		chk("synth_chan", 3'h5, synth_chan);
		@(negedge clk);
		chk("chan squelch", 3'h1, {2'h0, data_out});
		wait_fall(40, m);
		chk("chan time", 3'h1, {2'h0, n + m + 1 <= 40});
		$display("test chan done");
	endtask
	task automatic t_weak;
		signal_ok = 1'b0;
		repeat (2) @(negedge clk);
		chk("demod_ready", 3'h1, {2'h0, demod_ready});
		for (int i = 0; i < 8; i++) begin
			chk("squelch", 3'h1, {2'h0, data_out});
			@(negedge clk);
		end
		signal_ok = 1'b1;
		$display("test weak done");
	endtask
	task automatic t_pass;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			m = data_out;
			@(negedge clk);
			n += (m != data_out);
		end
		chk("toggles", 3'h1, {2'h0, n >= 5});
		$display("test pass done");
	endtask
	task automatic t_gap;
		hold = 1'b1;
		repeat (190) @(negedge clk);
		chk("gap early", 3'h0, {2'h0, gap_fault});
		repeat (20) @(negedge clk);
		chk("gap_fault", 3'h1, {2'h0, gap_fault});
		hold = 1'b0;
		repeat (8) @(negedge clk);
		chk("gap clear", 3'h0, {2'h0, gap_fault});
		$display("test gap done");
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		wait_fall(100, n);
		chk("cold wake", 3'h1, {2'h0, n <= 100});
		chk("serial_mode", 3'h0, {2'h0, serial_mode});
		$display("test cold done");
		t_pd();
		t_chan();
		t_weak();
		t_pass();
		t_gap();
		finish_test();
	end
	initial begin
		#50000;
		n_errors++;
		finish_test();
	end
endmodule
bind rxpsc_top rxpsc_sva rxpsc_sva_inst (.clk(clk), .rst_b(rst_b),
	.power_down_n(power_down_n), .chan_sel_bit0(chan_sel_bit0),
	.chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2),
	.signal_ok(signal_ok), .data_out(data_out), .synth_load(synth_load),
	.synth_chan(synth_chan), .rx_enable(rx_enable));
